// *** hw/led_sink_pkg.sv ***
/*
  Constants, types and defaults shared by the serial slave front end.
  Assumes nothing of its surroundings; every hw file uses it by package::name.
*/
package led_sink_pkg;
  // power-up values of the address, mode and current registers
  localparam logic [7:0] BCAST_RST  = 8'hD0;
  localparam logic [7:0] GROUP1_RST = 8'hD2;
  localparam logic [7:0] GROUP2_RST = 8'hD4;
  localparam logic [7:0] GROUP3_RST = 8'hD8;
  localparam logic [7:0] MODE_RST   = 8'h01;  // broadcast on, groups off
  localparam logic [7:0] CFG_RST    = 8'hFF;  // ratio select 1, gain 127/128
  // reserved reset call, fixed and never programmable
  localparam logic [6:0] RESET_CALL_ADDR = 7'h03;
  // field positions
  localparam int MODE_BCAST_BIT = 0;
  localparam int MODE_GRP_BIT0  = 1;
  localparam int CFG_RATIO_BIT  = 7;
  localparam int CTRL_STEP_LSB  = 5;
  // register offsets held in this block
  localparam logic [4:0] OFF_MODE     = 5'h00;
  localparam logic [4:0] OFF_CFG      = 5'h01;
  localparam logic [4:0] OFF_GRP_BASE = 5'h18;
  localparam logic [4:0] OFF_BCAST    = 5'h1B;
  // pointer rollover points and step mode codes
  localparam logic [4:0] PTR_LAST      = 5'h1B;
  localparam logic [4:0] PTR_LED_FIRST = 5'h02;
  localparam logic [4:0] PTR_LED_LAST  = 5'h11;
  localparam logic [4:0] PTR_GLB_FIRST = 5'h12;
  localparam logic [4:0] PTR_GLB_LAST  = 5'h13;
  localparam logic [2:0] STEP_ALL    = 3'h4;
  localparam logic [2:0] STEP_LED    = 3'h5;
  localparam logic [2:0] STEP_GLB    = 3'h6;
  localparam logic [2:0] STEP_LEDGLB = 3'h7;
  // output to reference current ratio, then bits per byte
  localparam logic [3:0] RATIO_HIGH = 4'hF;
  localparam logic [3:0] RATIO_LOW  = 4'h5;
  localparam logic [3:0] BYTE_BITS  = 4'h8;

  typedef enum logic [1:0] {
    KIND_CONTROL = 2'h0,
    KIND_DATA    = 2'h1,
    KIND_RESET   = 2'h2,
    KIND_IGNORE  = 2'h3
  } rx_kind_t;

  // address snapshot mirrored into the link domain
  typedef struct packed {
    logic            valid;
    logic [6:0]      own;
    logic [6:0]      bcast;
    logic [2:0][6:0] grp;
    logic [3:0]      en;   // [0] broadcast, [i+1] group i
  } link_cfg_t;
endpackage : led_sink_pkg

// *** hw/cross_if.sv ***
/*
  Toggle handshakes between the link engine and the register bank.
  Assumes each request holds its data until the matching acknowledge.
*/
`timescale 1ns/1ns
interface cross_if;
  logic                   rxReq;
  logic [7:0]             rxData;
  led_sink_pkg::rx_kind_t rxKind;
  logic                   rxAck;
  logic                   rdReq;
  logic [7:0]             rdData;
  logic                   rdAck;
  logic                   cfgReq;
  led_sink_pkg::link_cfg_t cfgWord;
  logic                   cfgAck;
  modport engine (output rxReq, rxData, rxKind, rdReq, cfgAck,
                  input rxAck, rdData, rdAck, cfgReq, cfgWord);
  modport bank (input rxReq, rxData, rxKind, rdReq, cfgAck,
                output rxAck, rdData, rdAck, cfgReq, cfgWord);
endinterface : cross_if

// *** hw/pointer_step.sv ***
/*
  Next register pointer for the selected step mode.
  Assumes a combinational user in the register clock domain.
*/
`timescale 1ns/1ns
module pointer_step (
  input  wire logic [4:0] ptr,
  input  wire logic [2:0] pointerStepMode,
  output logic      [4:0] nextPtr
);
  // rollover per mode; reserved codes hold the pointer
  always_comb begin
    case (pointerStepMode)
      led_sink_pkg::STEP_ALL:
        nextPtr = (ptr == led_sink_pkg::PTR_LAST) ? 5'h00 : ptr + 5'h01;
      led_sink_pkg::STEP_LED:
        nextPtr = (ptr == led_sink_pkg::PTR_LED_LAST) ? led_sink_pkg::PTR_LED_FIRST
                                                      : ptr + 5'h01;
      led_sink_pkg::STEP_GLB:
        nextPtr = (ptr == led_sink_pkg::PTR_GLB_LAST) ? led_sink_pkg::PTR_GLB_FIRST
                                                      : ptr + 5'h01;
      led_sink_pkg::STEP_LEDGLB:
        nextPtr = (ptr == led_sink_pkg::PTR_GLB_LAST) ? led_sink_pkg::PTR_LED_FIRST
                                                      : ptr + 5'h01;
      default: nextPtr = ptr;
    endcase
  end
endmodule : pointer_step

// *** hw/reg_bank.sv ***
/*
  Register side on mclk: control byte, mode, address and current registers.
  Assumes the link engine keeps at most one rx or read request open.
*/
`timescale 1ns/1ns
module reg_bank (
  input  wire logic       mclk,
  input  wire logic       srst,
  cross_if.bank           x,
  input  wire logic [6:0] addrStrap,
  input  wire logic [4:0] nextPtr,
  input  wire logic [7:0] regRdData,
  output logic      [7:0] ctrlByte,
  output logic      [7:0] primaryModeReg,
  output logic            currentRatioSelect,
  output logic      [6:0] referenceGain,
  output logic      [3:0] outputRatio,
  output logic            regWrStrobe,
  output logic      [4:0] regWrAddr,
  output logic      [7:0] regWrData,
  output logic            busResetCall
);
  typedef struct packed {
    logic [1:0]              rxSync, rdSync, ackSync;
    logic                    rxAck, rdAck, cfgReq;
    logic [7:0]              rdData;
    led_sink_pkg::link_cfg_t cfgWord;
    logic [6:0]              strap;
    logic                    strapDone;
    logic [7:0]              ctrl, mode, cfg, broadcastAddressReg;
    logic [2:0][7:0]         groupAddressReg;
    logic                    wrStb;
    logic [4:0]              wrAddr;
    logic [7:0]              wrData;
    logic                    resetCall;
    logic [3:0]              ratio;
  } bank_t;
  bank_t s, n;

  // one request served per cycle; rx first, the engine never opens both
  always_comb begin
    led_sink_pkg::link_cfg_t snap;
    logic [4:0] ptr;
    logic [7:0] rd;
    n = s;
    ptr = s.ctrl[4:0];
    rd = regRdData;
    snap = '0;
    n.rxSync = {s.rxSync[0], x.rxReq};
    n.rdSync = {s.rdSync[0], x.rdReq};
    n.ackSync = {s.ackSync[0], x.cfgAck};
    n.wrStb = 1'b0;
    n.resetCall = 1'b0;
    if (!s.strapDone) begin
      n.strap = addrStrap;  // strap caught once, first cycle after release
      n.strapDone = 1'b1;
    end
    if (ptr == led_sink_pkg::OFF_MODE) rd = s.mode;
    if (ptr == led_sink_pkg::OFF_CFG) rd = s.cfg;
    if (ptr == led_sink_pkg::OFF_BCAST) rd = s.broadcastAddressReg;
    for (int i = 0; i < 3; i++) begin
      if (ptr == led_sink_pkg::OFF_GRP_BASE + 5'(i)) rd = s.groupAddressReg[i];
    end
    if (s.rxSync[1] != s.rxAck) begin
      n.rxAck = s.rxSync[1];
      case (x.rxKind)
        led_sink_pkg::KIND_CONTROL: n.ctrl = x.rxData;  // [RULE_20]
        led_sink_pkg::KIND_DATA: begin
          n.wrStb = 1'b1;
          n.wrAddr = ptr;
          n.wrData = x.rxData;
          if (ptr == led_sink_pkg::OFF_MODE) n.mode = x.rxData;
          if (ptr == led_sink_pkg::OFF_CFG) n.cfg = x.rxData;
          if (ptr == led_sink_pkg::OFF_BCAST) n.broadcastAddressReg = x.rxData;  // [RULE_03]
          for (int i = 0; i < 3; i++) begin
            if (ptr == led_sink_pkg::OFF_GRP_BASE + 5'(i)) begin
              n.groupAddressReg[i] = x.rxData;  // [RULE_04]
            end
          end
          n.ctrl[4:0] = nextPtr;  // [RULE_21]
        end
        led_sink_pkg::KIND_RESET: n.resetCall = 1'b1;
        default: ;
      endcase
    end else if (s.rdSync[1] != s.rdAck) begin
      n.rdAck = s.rdSync[1];
      n.rdData = rd;
      n.ctrl[4:0] = nextPtr;  // [RULE_21]
    end
    // snapshot resent only after the previous one is taken
    snap.valid = s.strapDone;
    snap.own = s.strap;
    snap.bcast = s.broadcastAddressReg[7:1];
    snap.en[0] = s.mode[led_sink_pkg::MODE_BCAST_BIT];
    for (int i = 0; i < 3; i++) begin
      snap.grp[i] = s.groupAddressReg[i][7:1];
      snap.en[i+1] = s.mode[led_sink_pkg::MODE_GRP_BIT0 + i];  // [RULE_05]
    end
    if (s.ackSync[1] == s.cfgReq && snap != s.cfgWord) begin
      n.cfgWord = snap;
      n.cfgReq = ~s.cfgReq;
    end
    n.ratio = s.cfg[led_sink_pkg::CFG_RATIO_BIT] ? led_sink_pkg::RATIO_HIGH
                                                : led_sink_pkg::RATIO_LOW;  // [RULE_18]
  end

  // power-up defaults; address registers are volatile
  always_ff @(posedge mclk) begin
    if (srst) begin
      s <= '0;
      s.mode <= led_sink_pkg::MODE_RST;  // [RULE_05]
      s.cfg <= led_sink_pkg::CFG_RST;  // [RULE_19]
      s.ratio <= led_sink_pkg::RATIO_HIGH;
      s.broadcastAddressReg <= led_sink_pkg::BCAST_RST;  // [RULE_03]
      s.groupAddressReg <= {led_sink_pkg::GROUP3_RST, led_sink_pkg::GROUP2_RST,
                            led_sink_pkg::GROUP1_RST};  // [RULE_04]
    end else begin
      s <= n;
    end
  end

  assign x.rxAck = s.rxAck;
  assign x.rdAck = s.rdAck;
  assign x.rdData = s.rdData;
  assign x.cfgReq = s.cfgReq;
  assign x.cfgWord = s.cfgWord;
  assign ctrlByte = s.ctrl;
  assign primaryModeReg = s.mode;
  assign currentRatioSelect = s.cfg[led_sink_pkg::CFG_RATIO_BIT];
  assign referenceGain = s.cfg[6:0];
  assign outputRatio = s.ratio;
  assign regWrStrobe = s.wrStb;
  assign regWrAddr = s.wrAddr;
  assign regWrData = s.wrData;
  assign busResetCall = s.resetCall;

  a_ratio_track: assert property (@(posedge mclk) disable iff (srst) // [RULE_18]
    outputRatio == ($past(currentRatioSelect) ? 4'hF : 4'h5))
    else $error("current ratio does not follow select bit");
  a_power_defaults: assert property (@(posedge mclk) disable iff (srst) // [RULE_19]
    $fell(srst) |-> s.broadcastAddressReg == 8'hD0 && s.mode[3:0] == 4'h1
                    && s.cfg == 8'hFF && s.groupAddressReg[2] == 8'hD8)
    else $error("power-up defaults wrong");
endmodule : reg_bank

// *** hw/led_sink_i2c_slave.sv ***
/*
  Two-wire slave front end: the bus engine on linkClk plus the register
  bank on mclk. Assumes open-drain pads resolve the lines from the enables
  and that srst is held long enough to reach the link domain.
*/
`timescale 1ns/1ns
// Functional notes
// [RULE_01] master sends seven-bit address plus direction after start
// [RULE_02] last address bit: 1 means read, 0 means write
// [RULE_03] broadcast address resets to D0h, enabled, rewritable, volatile
// [RULE_04] group addresses reset to D2h, D4h, D8h, rewritable, volatile
// [RULE_05] all group addresses disabled at power-up, not acknowledged
// [RULE_06] master uses group address as plain address only if disabled
// [RULE_07] system never assigns D0h as an ordinary slave address
// [RULE_08] reset call acknowledged only for writes, never for reads
// [RULE_09] reset call address never programmed or assigned elsewhere
// [RULE_10] master starts only with both lines idle high
// [RULE_11] one bit per clock pulse; data steady while clock high
// [RULE_12] data falling with clock high is start, rising is stop
// [RULE_13] unlimited bytes, each eight bits plus one acknowledge clock
// [RULE_14] addressed receiver acknowledges address and every data byte
// [RULE_15] reading master acknowledges each byte except the last
// [RULE_16] acknowledger holds data low through the acknowledge high phase
// [RULE_17] after master not-acknowledge, device releases data line high
// [RULE_18] ratio select bit picks current ratio 15 or 5
// [RULE_19] power-on defaults: gain 127/128, ratio select 1
// [RULE_20] first written byte after address becomes the control byte
// [RULE_21] step mode advances the five-bit pointer with its rollover
// [RULE_22] unmatched address bytes are ignored without acknowledge
// [RULE_23] reset call compared against a fixed constant only
module led_sink_i2c_slave (
  input  wire logic       mclk,
  input  wire logic       srst,
  input  wire logic       linkClk,
  input  wire logic       sclIn,
  output logic            sclOut,
  output logic            sclOe,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  input  wire logic [6:0] addrStrap,
  input  wire logic [7:0] regRdData,
  output logic            currentRatioSelect,
  output logic      [6:0] referenceGain,
  output logic      [3:0] outputRatio,
  output logic      [7:0] primaryModeReg,
  output logic            regWrStrobe,
  output logic      [4:0] regWrAddr,
  output logic      [7:0] regWrData,
  output logic            busResetCall
);
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_AACK  = 3'b011,
    ST_RX    = 3'b010,
    ST_RXACK = 3'b110,
    ST_HOLD  = 3'b111,
    ST_TX    = 3'b101,
    ST_TXACK = 3'b100
  } link_state_t;

  typedef struct packed {
    logic [2:0]              sclSync, sdaSync;
    logic                    sclLvl, sdaLvl;
    link_state_t             st;
    logic [3:0]              bitCnt;
    logic [7:0]              shifter;
    logic                    rw, first, resetSel, txNext, masterAck;
    logic                    sdaOe, sclOe;
    logic                    rxReq, rdReq, cfgAck;
    logic [7:0]              rxData;
    led_sink_pkg::rx_kind_t  rxKind;
    logic [1:0]              rxAckSync, rdAckSync, cfgReqSync;
    led_sink_pkg::link_cfg_t cfg;
  } link_t;

  link_t       s, n;
  logic [1:0]  rstSync;
  logic        linkRst;
  logic        sclNew, sdaNew, sclRise, sclFall, startSeen, stopSeen;
  logic        rxPend, rdPend, ownHit, bcHit, resetHit, match, byteDone;
  logic [2:0]  grpHit;
  logic [6:0]  addr;
  logic [7:0]  ctrlByte;
  logic [4:0]  nextPtr;

  cross_if x ();

  // reset level carried into the link domain
  always_ff @(posedge linkClk) begin
    rstSync <= {rstSync[0], srst};
  end
  assign linkRst = rstSync[1];

  // a line level changes once the second and third stages agree
  assign sclNew = (s.sclSync[1] == s.sclSync[2]) ? s.sclSync[2] : s.sclLvl;
  assign sdaNew = (s.sdaSync[1] == s.sdaSync[2]) ? s.sdaSync[2] : s.sdaLvl;
  assign sclRise = !s.sclLvl && sclNew;
  assign sclFall = s.sclLvl && !sclNew;
  // data edges only count while clock stays high
  assign startSeen = s.sclLvl && sclNew && s.sdaLvl && !sdaNew;  // [RULE_12]
  assign stopSeen = s.sclLvl && sclNew && !s.sdaLvl && sdaNew;  // [RULE_12]
  assign rxPend = s.rxReq != s.rxAckSync[1];
  assign rdPend = s.rdReq != s.rdAckSync[1];
  assign byteDone = sclFall && s.bitCnt == led_sink_pkg::BYTE_BITS;

  // address compare against the mirrored snapshot
  assign addr = s.shifter[7:1];
  assign ownHit = addr == s.cfg.own;
  assign bcHit = s.cfg.en[0] && addr == s.cfg.bcast;
  generate
    for (genvar i = 0; i < 3; i++) begin : g_grp
      assign grpHit[i] = s.cfg.en[i+1] && addr == s.cfg.grp[i];  // [RULE_05]
    end
  endgenerate
  assign match = s.cfg.valid && (ownHit || bcHit || (|grpHit));
  // fixed constant, no register can move it; writes only
  assign resetHit = s.cfg.valid && addr == led_sink_pkg::RESET_CALL_ADDR
                    && !s.shifter[0];  // [RULE_08] [RULE_23]

  // bus engine; clock stretching covers the crossing latency
  always_comb begin
    n = s;
    n.sclSync = {s.sclSync[1:0], sclIn};
    n.sdaSync = {s.sdaSync[1:0], sdaIn};
    n.sclLvl = sclNew;
    n.sdaLvl = sdaNew;
    n.rxAckSync = {s.rxAckSync[0], x.rxAck};
    n.rdAckSync = {s.rdAckSync[0], x.rdAck};
    n.cfgReqSync = {s.cfgReqSync[0], x.cfgReq};
    n.sclOe = (s.st == ST_HOLD) ? s.sclOe : 1'b0;
    if (s.cfgReqSync[1] != s.cfgAck) begin
      n.cfg = x.cfgWord;
      n.cfgAck = s.cfgReqSync[1];
    end
    case (s.st)
      ST_IDLE: ;
      ST_ADDR: begin
        if (sclRise) begin
          n.shifter = {s.shifter[6:0], sdaNew};
          n.bitCnt = s.bitCnt + 4'h1;
        end else if (byteDone) begin
          if (match || resetHit) begin
            n.sdaOe = 1'b1;  // [RULE_14]
            n.st = ST_AACK;
            n.rw = s.shifter[0];  // [RULE_02]
            n.first = 1'b1;
            n.resetSel = resetHit && !match;
            if (s.shifter[0]) n.rdReq = ~s.rdReq;  // prefetch hides latency
            if (resetHit && !match) begin
              n.rxReq = ~s.rxReq;
              n.rxKind = led_sink_pkg::KIND_RESET;
            end
          end else begin
            n.st = ST_IDLE;  // [RULE_22]
          end
        end
      end
      ST_AACK: begin
        if (sclFall) begin  // [RULE_16]
          n.sdaOe = 1'b0;
          n.bitCnt = 4'h0;
          n.txNext = s.rw;
          n.st = s.rw ? ST_HOLD : ST_RX;
        end
      end
      ST_RX: begin
        if (sclRise) begin
          n.shifter = {s.shifter[6:0], sdaNew};
          n.bitCnt = s.bitCnt + 4'h1;  // [RULE_13]
        end else if (byteDone) begin
          n.sdaOe = 1'b1;  // [RULE_14]
          n.rxReq = ~s.rxReq;
          n.rxData = s.shifter;
          n.first = 1'b0;
          if (s.resetSel) n.rxKind = led_sink_pkg::KIND_IGNORE;
          else if (s.first) n.rxKind = led_sink_pkg::KIND_CONTROL;  // [RULE_20]
          else n.rxKind = led_sink_pkg::KIND_DATA;
          n.st = ST_RXACK;
        end
      end
      ST_RXACK: begin
        if (sclFall) begin  // [RULE_16]
          n.sdaOe = 1'b0;
          n.bitCnt = 4'h0;
          n.txNext = 1'b0;
          n.st = ST_HOLD;
        end
      end
      ST_HOLD: begin
        // data line set first, clock released a cycle later
        if (rxPend || rdPend) begin
          n.sclOe = 1'b1;
        end else if (s.txNext) begin
          n.shifter = x.rdData;
          n.sdaOe = !x.rdData[7];
          n.st = ST_TX;
        end else begin
          n.st = ST_RX;
        end
      end
      ST_TX: begin
        if (sclRise) begin
          n.bitCnt = s.bitCnt + 4'h1;
        end else if (byteDone) begin
          n.sdaOe = 1'b0;
          n.st = ST_TXACK;
        end else if (sclFall) begin
          n.shifter = {s.shifter[6:0], 1'b0};  // [RULE_11]
          n.sdaOe = !s.shifter[6];
        end
      end
      ST_TXACK: begin
        if (sclRise) begin
          n.masterAck = !sdaNew;
        end else if (sclFall) begin
          if (s.masterAck) begin
            n.rdReq = ~s.rdReq;
            n.txNext = 1'b1;
            n.bitCnt = 4'h0;
            n.st = ST_HOLD;
          end else begin
            n.st = ST_IDLE;  // [RULE_17]
          end
        end
      end
      default: n.st = ST_IDLE;
    endcase
    if (startSeen) begin
      n.st = ST_ADDR;
      n.bitCnt = 4'h0;
      n.sdaOe = 1'b0;
      n.sclOe = 1'b0;
    end else if (stopSeen) begin
      n.st = ST_IDLE;
      n.sdaOe = 1'b0;
      n.sclOe = 1'b0;
    end
  end

  // lines released and snapshot invalid until the bank sends one
  always_ff @(posedge linkClk) begin
    if (linkRst) begin
      s <= '0;
      s.sclSync <= 3'h7;
      s.sdaSync <= 3'h7;
      s.sclLvl <= 1'b1;
      s.sdaLvl <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign x.rxReq = s.rxReq;
  assign x.rxData = s.rxData;
  assign x.rxKind = s.rxKind;
  assign x.rdReq = s.rdReq;
  assign x.cfgAck = s.cfgAck;
  assign sdaOe = s.sdaOe;
  assign sclOe = s.sclOe;
  assign sdaOut = 1'b0;  // open drain: only ever pulls low
  assign sclOut = 1'b0;

  pointer_step u_step (
    .ptr             (ctrlByte[4:0]),
    .pointerStepMode (ctrlByte[7:led_sink_pkg::CTRL_STEP_LSB]),
    .nextPtr         (nextPtr)
  );

  reg_bank u_bank (
    .mclk               (mclk),
    .srst               (srst),
    .x                  (x),
    .addrStrap          (addrStrap),
    .nextPtr            (nextPtr),
    .regRdData          (regRdData),
    .ctrlByte           (ctrlByte),
    .primaryModeReg     (primaryModeReg),
    .currentRatioSelect (currentRatioSelect),
    .referenceGain      (referenceGain),
    .outputRatio        (outputRatio),
    .regWrStrobe        (regWrStrobe),
    .regWrAddr          (regWrAddr),
    .regWrData          (regWrData),
    .busResetCall       (busResetCall)
  );

  default clocking cb @(posedge linkClk); endclocking
  default disable iff (linkRst);

  sequence s_nackSlot;
    s.st == ST_TXACK && sclFall && !s.masterAck;
  endsequence
  sequence s_released;
    s.st == ST_IDLE && !s.sdaOe ##1 !s.sdaOe;
  endsequence

  a_start_to_addr: assert property (startSeen |=> s.st == ST_ADDR && s.bitCnt == 0) // [RULE_12]
    else $error("start not recognised");
  a_stop_release: assert property (stopSeen |=> s.st == ST_IDLE && !sdaOe && !sclOe) // [RULE_12]
    else $error("stop did not release the bus");
  a_ignore_unmatched: assert property ( // [RULE_22]
    s.st == ST_ADDR && byteDone && !match && !resetHit |=> s.st == ST_IDLE && !sdaOe)
    else $error("unmatched address acknowledged");
  a_reset_read_nak: assert property ( // [RULE_08]
    s.st == ST_ADDR && byteDone && addr == 7'h03 && s.shifter[0] && !match |=> !sdaOe)
    else $error("reset call acknowledged for read");
  a_rw_latched: assert property ( // [RULE_02]
    s.st == ST_ADDR && byteDone && match |=> s.rw == $past(s.shifter[0]) && sdaOe)
    else $error("direction bit not taken");
  a_ack_held: assert property ((s.st == ST_RXACK || s.st == ST_AACK) |-> sdaOe) // [RULE_16]
    else $error("acknowledge not held low");
  a_rx_event: assert property ( // [RULE_14]
    s.st == ST_RX && byteDone |=> s.rxReq != $past(s.rxReq) && s.rxData == $past(s.shifter))
    else $error("received byte not passed on");
  a_tx_stable: assert property (s.st == ST_TX && s.sclLvl |-> sdaOe == !s.shifter[7]) // [RULE_11]
    else $error("data line changed while clock high");
  a_nack_release: assert property (s_nackSlot |=> s_released) // [RULE_17]
    else $error("data line not released after not-acknowledge");
  a_hold_bounded: assert property (s.st == ST_HOLD |-> ##[1:200] s.st != ST_HOLD) // [RULE_13]
    else $error("clock stretch too long");
  a_bit_count: assert property ((s.st == ST_RX || s.st == ST_ADDR) |-> s.bitCnt <= 4'h8) // [RULE_13]
    else $error("bit count past one byte");
endmodule : led_sink_i2c_slave

// *** bench/bus_master.sv ***
/*
  Behavioural two-wire bus master driving open-drain pulls.
  Assumes the bench resolves each line with a pull-up from all pulls.
*/
`timescale 1ns/1ns
module bus_master (
  input  wire logic scl,
  input  wire logic sda,
  output logic      sclPull,
  output logic      sdaPull
);
  localparam int T = 200;
  // both lines released: bus idle
  initial begin
    sclPull = 1'b0;
    sdaPull = 1'b0;
  end
  // data falls while clock high
  task automatic start();
    sdaPull = 1'b1;
    #T;
    sclPull = 1'b1;
    #T;
  endtask : start
  // data changes only with clock low, sampled at the high phase
  task automatic bitx(input logic b, output logic r);
    sdaPull = !b;
    #T;
    sclPull = 1'b0;
    for (int i = 0; i < 200 && scl !== 1'b1; i++) #20;  // honour stretching
    #T;
    r = sda;
    sclPull = 1'b1;
    #T;
  endtask : bitx
  // eight bits msb first plus one acknowledge pulse
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q,
                      output logic k);
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(a, k);
  endtask : xfer
  // data rises while clock high
  task automatic stop();
    sdaPull = 1'b1;
    #T;
    sclPull = 1'b0;
    #T;
    sdaPull = 1'b0;
    #T;
  endtask : stop
endmodule : bus_master

// *** bench/led_sink_i2c_slave_tb.sv ***
/*
  Self-checking bench for the two-wire slave front end.
  Assumes pull-ups on both lines and a strap of 7'h60.
*/
`timescale 1ns/1ns
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin \
  $display("Error %s expected %h seen %h", n, e, s); err_count++; end end
module led_sink_i2c_slave_tb;
  logic       mclk = 1'b0, linkClk = 1'b0, srst = 1'b1;
  logic       sclOe, sdaOe, mScl, mSda, crs, strobe, rstCall;
  logic [6:0] gain;
  logic [3:0] ratio;
  logic [7:0] mode, wData;
  logic [4:0] wAddr;
  logic [4:0] wrAddr[$];
  int         err_count = 0, num_checks = 0, rstCalls = 0, cyc = 0;
  logic [7:0] rowAddr[10] = '{8'hC0, 8'hC1, 8'hD0, 8'hD1, 8'hD2, 8'hD5, 8'hD8, 8'h06,
                              8'h07, 8'h44};
  logic       rowAck[10] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
  wire        scl = ~(sclOe | mScl);
  wire        sda = ~(sdaOe | mSda);
  always #20 mclk = ~mclk;
  always #3 linkClk = ~linkClk;  // 6 ns, no phase relation to mclk
  // strap 7'h60 keeps clear of the broadcast and reset call addresses
  led_sink_i2c_slave i_led_sink_i2c_slave (.mclk(mclk), .srst(srst), .linkClk(linkClk),
    .sclIn(scl), .sclOut(), .sclOe(sclOe), .sdaIn(sda), .sdaOut(), .sdaOe(sdaOe),
    .addrStrap(7'h60), .regRdData(8'hA5), .currentRatioSelect(crs), .referenceGain(gain),
    .outputRatio(ratio), .primaryModeReg(mode), .regWrStrobe(strobe), .regWrAddr(wAddr),
    .regWrData(wData), .busResetCall(rstCall));
  bus_master i_bus_master (.scl(scl), .sda(sda), .sclPull(mScl), .sdaPull(mSda));
  task automatic wrap_up();
    if (err_count == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  // one address frame; a read is ended by not acknowledging its byte
  task automatic frame(input logic [7:0] a, output logic k, output logic [7:0] d);
    logic [7:0] q;
    logic       n;
    d = 8'h00;
    i_bus_master.start();
    i_bus_master.xfer(a, 1'b1, q, k);
    if (k === 1'b0 && a[0]) i_bus_master.xfer(8'hFF, 1'b1, d, n);
    i_bus_master.stop();
  endtask : frame
  // pulse capture mid-cycle, away from the launching edge; hang guard
  always @(negedge mclk) begin
    cyc <= cyc + 1;
    if (strobe === 1'b1) wrAddr.push_back(wAddr);
    if (rstCall === 1'b1) rstCalls++;
    if (cyc == 10000) begin
      err_count++;
      wrap_up();
    end
  end
  initial begin
    logic       k;
    logic [7:0] q;
    repeat (8) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    #1;
    `CHK("ratioSel", 1'b1, crs)
    `CHK("gain", 7'h7F, gain)
    `CHK("ratio", 4'hF, ratio)
    `CHK("mode", 8'h01, mode)
    repeat (60) @(posedge mclk);
    for (int i = 0; i < 10; i++) begin
      frame(rowAddr[i], k, q);
      `CHK("addrAck", rowAck[i], k)
    end
    `CHK("resetCalls", 1, rstCalls)
    // broadcast write: control byte, then mode and cfg; reset call never programmed
    i_bus_master.start();
    i_bus_master.xfer(8'hD0, 1'b1, q, k);
    i_bus_master.xfer(8'h80, 1'b1, q, k);
    i_bus_master.xfer(8'h03, 1'b1, q, k);
    i_bus_master.xfer(8'h40, 1'b1, q, k);
    `CHK("dataAck", 1'b0, k)
    i_bus_master.stop();
    repeat (20) @(posedge mclk);
    `CHK("wrCount", 2, wrAddr.size())
    `CHK("wrAddr0", 5'h00, wrAddr[0])
    `CHK("wrAddr1", 5'h01, wrAddr[1])
    `CHK("wrData", 8'h40, wData)
    `CHK("mode", 8'h03, mode)
    `CHK("ratioSel", 1'b0, crs)
    `CHK("ratio", 4'h5, ratio)
    `CHK("gain", 7'h40, gain)
    frame(8'hD2, k, q);
    `CHK("groupAck", 1'b0, k)
    // pointer left at 2 by the writes, so the prefetch fetches the external byte
    frame(8'hC1, k, q);
    `CHK("readAck", 1'b0, k)
    `CHK("rdData", 8'hA5, q)
    wrap_up();
  end
endmodule : led_sink_i2c_slave_tb
